// *** hw/bbf_ctrl.sv ***
// Purpose: APB-driven host for a boot-block parallel flash
// Assumes: 100 MHz pclk, flash pins asynchronous to it
// Notes: Function
`timescale 1ns/1ps
`default_nettype none
module bbf_ctrl #(
    parameter int TO_PROG_US = bbf_pkg::TO_PROG_US,
    parameter int TO_BOOT_US = bbf_pkg::TO_BOOT_US,
    parameter int TO_PARAM_US = bbf_pkg::TO_PARAM_US,
    parameter int TO_MAIN_US = bbf_pkg::TO_MAIN_US
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output logic [16:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic deep_powerdown_pin_n,
    output logic signature_voltage_address_pin_hv,
    output logic vpp_en
);
    localparam int TW = bbf_pkg::TO_W;

    bbf_pkg::bbf_ctl_s s_r;
    bbf_pkg::bbf_ctl_s s_nxt;
    logic [7:0] dq_sync;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic tmr_exp;
    logic sel_ctrl;
    logic mapped;
    logic start_bad;
    logic wacc;
    logic [31:0] rd_word;

    bbf_sync #(.W(8)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(flash_dq_i),
        .q(dq_sync)
    );

    bbf_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .val(tmr_val),
        .expired(tmr_exp)
    );

    function automatic logic [7:0] first_byte(bbf_pkg::bbf_op_e op,
                                              logic [7:0] wd);
        case (op)
            bbf_pkg::OP_ARRAY: first_byte = bbf_pkg::CMD_ARRAY;
            bbf_pkg::OP_PROG: first_byte = bbf_pkg::CMD_PROG;
            bbf_pkg::OP_ERASE: first_byte = bbf_pkg::CMD_ERASE;
            bbf_pkg::OP_STATUS: first_byte = bbf_pkg::CMD_STATUS;
            bbf_pkg::OP_CLEAR: first_byte = bbf_pkg::CMD_CLEAR;
            bbf_pkg::OP_SIG: first_byte = bbf_pkg::CMD_SIG;
            bbf_pkg::OP_SUSP: first_byte = bbf_pkg::CMD_SUSP;
            bbf_pkg::OP_RESUME: first_byte = bbf_pkg::CMD_CONFIRM;
            default: first_byte = wd;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        tmr_load = 1'b0;
        rd_word = '0;
        // Timeout by operation and block size
        if (s_r.op == bbf_pkg::OP_PROG) begin
            tmr_val = TW'(TO_PROG_US);
        end else if (s_r.blk == bbf_pkg::BLK_BOOT) begin
            tmr_val = TW'(TO_BOOT_US);
        end else if (s_r.blk == bbf_pkg::BLK_PARAM) begin
            tmr_val = TW'(TO_PARAM_US);
        end else begin
            tmr_val = TW'(TO_MAIN_US);
        end
        // Register access
        wacc = psel && penable && pwrite;
        sel_ctrl = (paddr == bbf_pkg::REG_CTRL);
        mapped = sel_ctrl || paddr == bbf_pkg::REG_ADDR ||
            paddr == bbf_pkg::REG_WDATA || paddr == bbf_pkg::REG_STAT ||
            paddr == bbf_pkg::REG_PINS;
        start_bad = sel_ctrl && pwrite &&
            (s_r.busy || !s_r.rp_n || pwdata[3:0] > 4'h9);
        unique case (paddr)
            bbf_pkg::REG_CTRL: rd_word[3:0] = s_r.op;
            bbf_pkg::REG_ADDR: rd_word[16:0] = s_r.addr;
            bbf_pkg::REG_WDATA: rd_word[7:0] = s_r.wdata;
            bbf_pkg::REG_STAT: begin
                rd_word[bbf_pkg::STAT_BUSY] = s_r.busy;
                rd_word[bbf_pkg::STAT_DONE] = s_r.done;
                rd_word[bbf_pkg::STAT_TOUT] = s_r.tout;
                rd_word[bbf_pkg::STAT_RD_LSB +: 8] = s_r.rdata;
            end
            bbf_pkg::REG_PINS: begin
                rd_word[bbf_pkg::PINS_RP] = s_r.rp_n;
                rd_word[bbf_pkg::PINS_A9] = s_r.a9hv;
                rd_word[bbf_pkg::PINS_VPP] = s_r.vpp;
                rd_word[bbf_pkg::PINS_BLK_LSB +: 2] = s_r.blk;
            end
            default: rd_word = '0;
        endcase
        if (psel && !penable) begin
            s_nxt.prdata = rd_word;
        end
        // Powerdown release recovery count
        if (s_r.ps != 8'h00) begin
            s_nxt.ps = s_r.ps - 8'h01;
        end
        if (wacc && !start_bad) begin
            unique case (paddr)
                bbf_pkg::REG_CTRL: begin
                    s_nxt.op = bbf_pkg::bbf_op_e'(pwdata[3:0]);
                    s_nxt.go = 1'b1;
                    s_nxt.busy = 1'b1;
                    s_nxt.done = 1'b0;
                    s_nxt.tout = 1'b0;
                    s_nxt.phase = 1'b0;
                    s_nxt.poll = 1'b0;
                end
                bbf_pkg::REG_ADDR: s_nxt.addr = pwdata[16:0];
                bbf_pkg::REG_WDATA: s_nxt.wdata = pwdata[7:0];
                bbf_pkg::REG_PINS: begin
                    s_nxt.rp_n = pwdata[bbf_pkg::PINS_RP];
                    s_nxt.a9hv = pwdata[bbf_pkg::PINS_A9];
                    s_nxt.vpp = pwdata[bbf_pkg::PINS_VPP];
                    s_nxt.blk = pwdata[bbf_pkg::PINS_BLK_LSB +: 2];
                    if (pwdata[bbf_pkg::PINS_RP] && !s_r.rp_n) begin
                        s_nxt.ps = bbf_pkg::N_PS;
                    end
                end
                default: s_nxt.go = s_r.go;
            endcase
        end
        // Pin sequencer
        s_nxt.cnt = s_r.cnt - 8'h01;
        unique case (s_r.st)
            bbf_pkg::ST_IDLE: begin
                s_nxt.cnt = 8'h00;
                if (s_r.go && s_r.ps == 8'h00 && s_r.rp_n) begin
                    s_nxt.go = 1'b0;
                    s_nxt.ce_n = 1'b0;
                    s_nxt.fa = s_r.addr;
                    if (s_r.op == bbf_pkg::OP_READ) begin
                        s_nxt.st = bbf_pkg::ST_RLOW;
                        s_nxt.oe_n = 1'b0;
                        s_nxt.cnt = bbf_pkg::N_RD - 8'h01;
                    end else begin
                        s_nxt.st = bbf_pkg::ST_WLOW;
                        s_nxt.we_n = 1'b0;
                        s_nxt.dq_oe_n = 1'b0;
                        s_nxt.dq_o = first_byte(s_r.op, s_r.wdata);
                        s_nxt.cnt = bbf_pkg::N_WP - 8'h01;
                    end
                end
            end
            bbf_pkg::ST_WLOW: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.we_n = 1'b1;
                    s_nxt.st = bbf_pkg::ST_WHOLD;
                    s_nxt.cnt = bbf_pkg::N_WH - 8'h01;
                end
            end
            bbf_pkg::ST_WHOLD: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.dq_oe_n = 1'b1;
                    s_nxt.ce_n = 1'b1;
                    if (!s_r.phase && (s_r.op == bbf_pkg::OP_PROG ||
                        s_r.op == bbf_pkg::OP_ERASE)) begin
                        s_nxt.phase = 1'b1;
                        s_nxt.st = bbf_pkg::ST_WLOW;
                        s_nxt.ce_n = 1'b0;
                        s_nxt.we_n = 1'b0;
                        s_nxt.dq_oe_n = 1'b0;
                        s_nxt.cnt = bbf_pkg::N_WP - 8'h01;
                        s_nxt.dq_o = (s_r.op == bbf_pkg::OP_PROG) ?
                            s_r.wdata : bbf_pkg::CMD_CONFIRM;
                    end else if (s_r.op == bbf_pkg::OP_STATUS ||
                        s_r.op == bbf_pkg::OP_SIG) begin
                        s_nxt.st = bbf_pkg::ST_RGAP;
                        s_nxt.cnt = bbf_pkg::N_GAP - 8'h01;
                        if (s_r.op == bbf_pkg::OP_SIG) begin
                            s_nxt.fa = {16'h0000, s_r.addr[0]};
                        end
                    end else if (s_r.op == bbf_pkg::OP_PROG ||
                        s_r.op == bbf_pkg::OP_ERASE ||
                        s_r.op == bbf_pkg::OP_SUSP ||
                        s_r.op == bbf_pkg::OP_RESUME) begin
                        s_nxt.poll = 1'b1;
                        s_nxt.rdata = 8'h00;
                        s_nxt.st = bbf_pkg::ST_RGAP;
                        s_nxt.cnt = bbf_pkg::N_GAP - 8'h01;
                        tmr_load = 1'b1;
                    end else begin
                        s_nxt.st = bbf_pkg::ST_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end
            end
            bbf_pkg::ST_RLOW: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.rdata = dq_sync;
                    s_nxt.ce_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.st = bbf_pkg::ST_RGAP;
                    s_nxt.cnt = bbf_pkg::N_GAP - 8'h01;
                end
            end
            bbf_pkg::ST_RGAP: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.st = bbf_pkg::ST_IDLE;
                    if (s_r.poll && s_r.rdata[bbf_pkg::SR_READY]) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end else if (s_r.poll && tmr_exp) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.tout = 1'b1;
                    end else if (s_r.poll || (!s_r.phase &&
                        (s_r.op == bbf_pkg::OP_STATUS ||
                        s_r.op == bbf_pkg::OP_SIG))) begin
                        s_nxt.st = bbf_pkg::ST_RLOW;
                        s_nxt.ce_n = 1'b0;
                        s_nxt.oe_n = 1'b0;
                        s_nxt.cnt = bbf_pkg::N_RD - 8'h01;
                        s_nxt.phase = 1'b1;
                    end else begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= bbf_pkg::CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || start_bad);
    assign prdata = s_r.prdata;
    assign flash_addr = s_r.fa;
    assign flash_dq_o = s_r.dq_o;
    assign flash_dq_oe_n = s_r.dq_oe_n;
    assign flash_ce_n = s_r.ce_n;
    assign flash_oe_n = s_r.oe_n;
    assign flash_we_n = s_r.we_n;
    assign deep_powerdown_pin_n = s_r.rp_n;
    assign signature_voltage_address_pin_hv = s_r.a9hv;
    assign vpp_en = s_r.vpp;

    // Cycles since powerdown release, for checking only
    logic [7:0] rp_age;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rp_age <= 8'h00;
        end else if (!s_r.rp_n) begin
            rp_age <= 8'h00;
        end else if (rp_age != 8'hFF) begin
            rp_age <= rp_age + 8'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_write_strobe: assert property (
        $fell(s_r.we_n) |-> !s_r.ce_n && s_r.oe_n && !s_r.dq_oe_n ##1
        !s_r.we_n[*3] ##1 s_r.we_n && !s_r.dq_oe_n)
        else $error("write strobe shape wrong");
    chk_array_code: assert property (
        $fell(s_r.we_n) && s_r.op == bbf_pkg::OP_ARRAY |->
        s_r.dq_o == 8'hFF) else $error("array code wrong");
    chk_prog_pair: assert property (
        $fell(s_r.we_n) && s_r.op == bbf_pkg::OP_PROG |->
        s_r.dq_o == (s_r.phase ? s_r.wdata : 8'h40))
        else $error("program byte wrong");
    chk_status_read: assert property (
        $fell(s_r.we_n) && s_r.op == bbf_pkg::OP_STATUS |->
        s_r.dq_o == 8'h70 ##[1:30] $fell(s_r.oe_n))
        else $error("status read missing");
    chk_clear_code: assert property (
        $fell(s_r.we_n) && s_r.op == bbf_pkg::OP_CLEAR |->
        s_r.dq_o == 8'h50) else $error("clear code wrong");
    chk_erase_confirm: assert property (
        $rose(s_r.phase) && s_r.op == bbf_pkg::OP_ERASE |->
        s_r.dq_o == 8'hD0 && $stable(s_r.fa))
        else $error("erase confirm wrong");
    chk_suspend_code: assert property (
        $fell(s_r.we_n) && s_r.op == bbf_pkg::OP_SUSP |->
        s_r.dq_o == 8'hB0) else $error("suspend code wrong");
    chk_sig_address: assert property (
        $fell(s_r.oe_n) && s_r.op == bbf_pkg::OP_SIG |->
        s_r.fa[16:1] == 16'h0000) else $error("signature address wrong");
    chk_rp_recovery: assert property (
        $fell(s_r.we_n) |-> rp_age >= bbf_pkg::N_PS)
        else $error("write too soon after powerdown release");
    chk_timeout_cause: assert property (
        $rose(s_r.tout) |-> $past(tmr_exp) && $past(s_r.poll))
        else $error("timeout without expiry");

    cov_prog_done: cover property (
        s_r.op == bbf_pkg::OP_PROG && $rose(s_r.done));
    cov_erase_tout: cover property (
        s_r.op == bbf_pkg::OP_ERASE && $rose(s_r.tout));
    cov_sig_read: cover property (
        s_r.op == bbf_pkg::OP_SIG && $rose(s_r.done));
endmodule
`default_nettype wire

// *** pkg/bbf_pkg.sv ***
// Purpose: Shared constants and types for the boot-block flash host
// Assumes: 100 MHz pclk, APB register access
// Notes: Times are kept in their own units; cycle counts derive from them
package bbf_pkg;
    // Clock and pin timing
    localparam int CLK_MHZ = 100;
    localparam int T_WP_NS = 40;
    localparam int T_WC_NS = 120;
    localparam int T_ACC_NS = 120;
    localparam int T_OEH_NS = 20;
    localparam int T_PS_NS = 480;
    localparam int TICK_NS = 1000;
    localparam logic [7:0] N_SYNC = 8'h02;
    localparam logic [7:0] N_WP = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] N_WH =
        8'(((T_WC_NS - T_WP_NS) * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] N_RD =
        8'((T_ACC_NS * CLK_MHZ + 999) / 1000) + N_SYNC;
    localparam logic [7:0] N_GAP = 8'((T_OEH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] N_PS = 8'((T_PS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [6:0] N_TICK = 7'((TICK_NS * CLK_MHZ) / 1000);

    // Longest operation times, counted in microsecond ticks
    localparam real PROG_MAX_S = 0.52;
    localparam real ERASE_BOOT_MAX_S = 14.9;
    localparam real ERASE_PARAM_MAX_S = 14.6;
    localparam real ERASE_MAIN_MAX_S = 20.9;
    localparam int TO_PROG_US = $rtoi(PROG_MAX_S * 1.0e6);
    localparam int TO_BOOT_US = $rtoi(ERASE_BOOT_MAX_S * 1.0e6);
    localparam int TO_PARAM_US = $rtoi(ERASE_PARAM_MAX_S * 1.0e6);
    localparam int TO_MAIN_US = $rtoi(ERASE_MAIN_MAX_S * 1.0e6);
    localparam int TO_W = 25;

    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_PINS = 8'h10;

    // Field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_TOUT = 2;
    localparam int STAT_RD_LSB = 8;
    localparam int PINS_RP = 0;
    localparam int PINS_A9 = 1;
    localparam int PINS_VPP = 2;
    localparam int PINS_BLK_LSB = 4;
    localparam int SR_READY = 7;

    // Command bytes
    localparam logic [7:0] CMD_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR = 8'h50;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSP = 8'hB0;
    localparam logic [7:0] CMD_SIG = 8'h90;

    localparam logic [1:0] BLK_BOOT = 2'h0;
    localparam logic [1:0] BLK_PARAM = 2'h1;

    typedef enum logic [3:0] {
        OP_RAW = 4'h0,
        OP_READ = 4'h1,
        OP_ARRAY = 4'h2,
        OP_PROG = 4'h3,
        OP_ERASE = 4'h4,
        OP_STATUS = 4'h5,
        OP_CLEAR = 4'h6,
        OP_SIG = 4'h7,
        OP_SUSP = 4'h8,
        OP_RESUME = 4'h9
    } bbf_op_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WLOW = 5'h02,
        ST_WHOLD = 5'h04,
        ST_RLOW = 5'h08,
        ST_RGAP = 5'h10
    } bbf_st_e;

    typedef struct packed {
        bbf_st_e st;
        bbf_op_e op;
        logic phase;
        logic poll;
        logic go;
        logic [7:0] cnt;
        logic [7:0] ps;
        logic [16:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic busy;
        logic done;
        logic tout;
        logic rp_n;
        logic a9hv;
        logic vpp;
        logic [1:0] blk;
        logic [31:0] prdata;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
        logic [7:0] dq_o;
        logic [16:0] fa;
    } bbf_ctl_s;

    localparam bbf_ctl_s CTL_RST = '{st: ST_IDLE, op: OP_RAW, ps: N_PS,
        rp_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
        default: '0};
endpackage

// *** hw/bbf_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to pclk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module bbf_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bbf_sync_s;

    bbf_sync_s s_r;
    bbf_sync_s s_nxt;

    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule
`default_nettype wire

// *** hw/bbf_timer.sv ***
// Purpose: Microsecond timeout counter for status polling
// Assumes: 100 MHz pclk
// Notes: Expired is high whenever the count sits at zero
`timescale 1ns/1ps
`default_nettype none
module bbf_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [bbf_pkg::TO_W-1:0] val,
    output logic expired
);
    typedef struct packed {
        logic [bbf_pkg::TO_W-1:0] cnt;
        logic [6:0] div;
    } bbf_tmr_s;

    bbf_tmr_s s_r;
    bbf_tmr_s s_nxt;
    logic tick;

    always_comb begin
        s_nxt = s_r;
        tick = (s_r.div == 7'h00);
        s_nxt.div = tick ? bbf_pkg::N_TICK - 7'h01 : s_r.div - 7'h01;
        if (load) begin
            s_nxt.cnt = val;
            s_nxt.div = bbf_pkg::N_TICK - 7'h01;
        end else if (tick && s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = (s_r.cnt == '0);
endmodule
`default_nettype wire

// *** verif/bbf_flash_model.sv ***
// Purpose: Behavioural boot-block flash device
// Assumes: Pin strobes come from the host controller
// Notes: Ids are arbitrary values; erase time is shortened
`timescale 1ns/1ps
`default_nettype none
module bbf_flash_model #(
    parameter int PROG_NS = 15000,
    parameter int ERASE_NS = 20000,
    parameter logic [7:0] MAKER_ID = 8'hA5,
    parameter logic [7:0] DEV_ID = 8'h5A
) (
    // Flash pins
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rp_n,
    input wire logic hv,
    input wire logic vpp,
    output logic [7:0] dq_out,
    output logic dq_oe_n
);
    logic [7:0] mem [int];
    logic [7:0] sr = 8'h80;
    logic [7:0] pend = 8'h00;
    logic [7:0] cur;
    logic prog = 1'b0;
    int mode = 0;
    int gen = 0;
    task automatic run(input int t, input logic p);
        int g;
        gen++;
        g = gen;
        sr[7] = 1'b0;
        prog = p;
        mode = 1;
        fork
            begin
                #t;
                if (g == gen) begin
                    sr[7] = 1'b1;
                    prog = 1'b0;
                end
            end
        join_none
    endtask
    always @(negedge rp_n) begin
        gen++;
        sr = 8'h80;
        mode = 0;
        pend = 8'h00;
    end
    always @(posedge we_n) begin
        if (rp_n && !ce_n && oe_n) begin
            cur = pend;
            pend = 8'h00;
            if (cur == 8'h20) begin
                if (dq_in == 8'hD0) begin
                    mem.delete();
                    run(ERASE_NS, 1'b0);
                end
            end else if (cur != 8'h00) begin
                if (vpp) mem[addr] = dq_in;
                else sr[4:3] = 2'b11;
                run(PROG_NS, 1'b1);
            end else if (prog) begin
                if (dq_in == 8'h70) mode = 1;
            end else begin
                case (dq_in)
                    8'hFF: mode = 0;
                    8'h70: mode = 1;
                    8'h50: sr[5:3] = 3'b000;
                    8'h90: mode = 2;
                    8'h40, 8'h10, 8'h20: pend = dq_in;
                    8'hB0: if (!sr[7]) begin
                        gen++;
                        sr[7:6] = 2'b11;
                    end
                    8'hD0: if (sr[6]) begin
                        sr[6] = 1'b0;
                        run(ERASE_NS, 1'b0);
                    end
                    default: ;
                endcase
            end
        end
    end
    assign dq_oe_n = !(rp_n && !ce_n && !oe_n && we_n);
    initial dq_out = 8'h00;
    always @(negedge dq_oe_n) begin
        if (mode == 1) dq_out = sr;
        else if (mode == 2 || hv) dq_out = addr[0] ? DEV_ID : MAKER_ID;
        else dq_out = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
    always @(posedge dq_oe_n) dq_out = ~dq_out;
endmodule
`default_nettype wire

// *** verif/bbf_ctrl_bench.sv ***
// Purpose: Self-checking bench for the flash host
// Assumes: APB master tasks, behavioural flash beside it
// Notes: Poll timeouts shortened by parameter
`timescale 1ns/1ps
`default_nettype none
module bbf_ctrl_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, err, ce_n, oe_n, we_n, rp_n, hv, vpp, c_oe_n;
    logic m_oe_n;
    logic [16:0] fa;
    logic [7:0] c_dq, m_dq, dq;
    int bad_count = 0, compares = 0;
    assign dq = !m_oe_n ? m_dq : (!c_oe_n ? c_dq : m_dq);
    initial forever #5 pclk = ~pclk;
    bbf_ctrl #(.TO_PROG_US(50), .TO_BOOT_US(50), .TO_PARAM_US(5),
        .TO_MAIN_US(60)) i_bbf_ctrl(.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(fa), .flash_dq_i(dq),
        .flash_dq_o(c_dq), .flash_dq_oe_n(c_oe_n), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .deep_powerdown_pin_n(rp_n),
        .signature_voltage_address_pin_hv(hv), .vpp_en(vpp));
    bbf_flash_model i_bbf_flash_model(.addr(fa), .dq_in(dq), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .hv(hv), .vpp(vpp),
        .dq_out(m_dq), .dq_oe_n(m_oe_n));
    task automatic tally_and_finish;
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic go(input logic [3:0] c);
        apb(1, bbf_pkg::REG_CTRL, c);
        repeat (4) @(posedge pclk);
        do apb(0, bbf_pkg::REG_STAT, 0); while (rv[0] !== 1'b0);
    endtask
    task automatic run_op(input logic [3:0] c, input logic [7:0] e);
        go(c);
        chk("byte", e, rv[15:8]);
        chk("tout", 0, rv[2]);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, bbf_pkg::REG_PINS, 0);
        chk("pins", 32'h1, rv);
        apb(1, bbf_pkg::REG_PINS, 5);
        apb(1, bbf_pkg::REG_ADDR, 32'h12);
        apb(1, bbf_pkg::REG_WDATA, 32'h3C);
        run_op(3, 8'h80);
        run_op(1, 8'h80);
        go(2);
        run_op(1, 8'h3C);
        apb(1, bbf_pkg::REG_WDATA, 0);
        go(0);
        run_op(1, 8'h3C);
        apb(1, bbf_pkg::REG_ADDR, 0);
        run_op(7, 8'hA5);
        apb(1, bbf_pkg::REG_ADDR, 1);
        run_op(7, 8'h5A);
        go(2);
        apb(1, bbf_pkg::REG_PINS, 7);
        run_op(1, 8'h5A);
        apb(1, bbf_pkg::REG_PINS, 5);
        apb(1, bbf_pkg::REG_ADDR, 32'h12);
        run_op(4, 8'h80);
        go(2);
        run_op(1, 8'hFF);
        apb(1, bbf_pkg::REG_WDATA, 32'h20);
        go(0);
        apb(1, bbf_pkg::REG_WDATA, 32'hD0);
        go(0);
        run_op(8, 8'hC0);
        run_op(9, 8'h80);
        apb(1, bbf_pkg::REG_PINS, 1);
        run_op(3, 8'h98);
        go(6);
        run_op(5, 8'h80);
        apb(1, bbf_pkg::REG_PINS, 32'h15);
        go(4);
        chk("tout", 1, rv[2]);
        apb(1, bbf_pkg::REG_PINS, 32'h14);
        apb(1, bbf_pkg::REG_CTRL, 1);
        chk("refuse", 1, err);
        apb(1, bbf_pkg::REG_PINS, 5);
        run_op(1, 8'hFF);
        apb(0, 8'h40, 0);
        chk("unmapped", 1, err);
        tally_and_finish();
    end
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
